// ==== hw/itw_pkg.sv ====
// Package: register map, field layouts, reset values and timing for the interval timer and watchdog
package itw_pkg;

  // Register indices; the byte address is four times the index
  localparam logic [9:0] IDX_INTERVAL_CLOCK_CONTROL = 10'h08B;
  localparam logic [9:0] IDX_INTERVAL_COUNT_VALUE = 10'h08C;
  localparam logic [9:0] IDX_WATCHDOG_MODE_CONTROL = 10'h08D;
  localparam logic [9:0] IDX_WATCHDOG_COMPARE_VALUE = 10'h08E;
  localparam logic [9:0] IDX_WATCHDOG_COUNT_VALUE = 10'h08E;
  localparam logic [9:0] IDX_IRQ_STATUS = 10'h090;
  localparam logic [9:0] IDX_IRQ_MASK = 10'h091;

  // Reset values
  localparam logic [7:0] RST_INTERVAL_CLOCK_CONTROL = 8'h05;
  localparam logic [7:0] RST_INTERVAL_COUNT_VALUE = 8'h00;
  localparam logic [7:0] RST_WATCHDOG_MODE_CONTROL = 8'h00;
  localparam logic [7:0] RST_WATCHDOG_COMPARE_VALUE = 8'hFF;
  localparam logic [7:0] RST_WATCHDOG_COUNT_VALUE = 8'h00;
  localparam logic [1:0] RST_IRQ_STATUS = 2'h0;
  localparam logic [1:0] RST_IRQ_MASK = 2'h0;

  // Bit positions in the interrupt status and mask registers
  localparam int IRQ_BIT_INTERVAL = 0;
  localparam int IRQ_BIT_WATCHDOG = 1;

  // Timing: interval clock period is half the shortest overflow period
  localparam int CLK_PERIOD_NS = 10;
  localparam int INTERVAL_TICK_NS = 256000;
  localparam int INTERVAL_TICK_CYCLES = INTERVAL_TICK_NS / CLK_PERIOD_NS;

  // AXI4-Lite responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Interval clock control layout
  typedef struct packed {
    logic interval_flag;
    logic [2:0] reserved;
    logic interval_clear;
    logic [2:0] interval_period_select;
  } interval_ctrl_t;

  // Watchdog mode control layout
  typedef struct packed {
    logic watchdog_run_enable;
    logic watchdog_reset_select;
    logic watchdog_counter_clear;
    logic [3:0] reserved;
    logic watchdog_irq_flag;
  } watchdog_mode_t;

  // Decoded register write carried to the register processes
  typedef struct packed {
    logic fire;
    logic [9:0] index;
    logic [7:0] data;
  } reg_write_t;

endpackage : itw_pkg

// ==== hw/interval_timer_watchdog.sv ====
// Interval timer and malfunction_timer watchdog with an AXI4-Lite register slave
`timescale 1ns/1ns
`default_nettype none

// Operation
// - Eight-bit interval counter always runs, unstoppable
// - Interval overflow alone clocks the watchdog counter
// - Clear bit zeroes counter, self-clears next cycle
// - Overflow sets interval flag; software writes zero
// - Period select doubles from 0.512 ms
// - Interval counter times clock stabilisation wait
// - Count register reads live count, ignores writes
// - Watchdog count equal to compare raises request
// - Reset select picks interrupt or CPU reset
// - Watchdog clear bit zeroes counter, self-clears
// - Watchdog interval is overflow period times compare+1
// - Compare writes and count reads share address
// - Run enable starts watchdog, resets to zero
// - Watchdog flag cleared by zero write or acknowledge
module interval_timer_watchdog #(
  parameter int TICK_CYCLES = itw_pkg::INTERVAL_TICK_CYCLES,
  parameter int ADDR_W = 12
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // AXI4-Lite write address
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // CPU core side
  input wire logic int_ack,
  input wire logic stop_exit,
  output logic irq,
  output logic cpu_reset_req,
  output logic clock_stable
);
  import itw_pkg::*;

  logic [ADDR_W-1:0] aw_addr;
  logic aw_held;
  logic [7:0] w_data;
  logic w_lane0;
  logic w_held;
  reg_write_t wr;
  logic wr_mapped;

  logic [15:0] presc;
  logic tick;
  logic [7:0] interval_count;
  logic [8:0] span;
  logic [7:0] period_mask;
  logic overflow;
  logic wrap;

  interval_ctrl_t ictl;
  watchdog_mode_t wmode;
  logic [7:0] compare_value;
  logic [7:0] watchdog_count;
  logic match_event;
  logic [1:0] irq_status;
  logic [1:0] irq_mask;
  logic stab_wait;

  logic [9:0] rd_index;
  logic [7:0] rd_value;
  logic rd_mapped;

  logic wr_ictl;
  logic wr_wmode;
  logic wr_cmp;
  logic wr_stat;
  logic wr_mask;

  // ---------------- AXI4-Lite write channels ----------------
  // A response still waiting for bready blocks both address and data
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready = !w_held && !s_axi_bvalid;

  always_ff @(posedge core_clk) begin
    if (srst) begin
      aw_held <= 1'b0;
      aw_addr <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held <= 1'b1;
      aw_addr <= s_axi_awaddr;
    end else if (wr.fire) begin
      aw_held <= 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      w_held <= 1'b0;
      w_data <= 8'h00;
      w_lane0 <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held <= 1'b1;
      w_data <= s_axi_wdata[7:0];
      w_lane0 <= s_axi_wstrb[0];
    end else if (wr.fire) begin
      w_held <= 1'b0;
    end
  end

  // Write commits once both halves are held; a cleared low strobe writes nothing
  always_comb begin
    wr.fire = aw_held && w_held && !s_axi_bvalid;
    wr.index = aw_addr[11:2];
    wr.data = w_data;
  end

  always_comb begin
    case (wr.index)
      IDX_INTERVAL_CLOCK_CONTROL,
      IDX_INTERVAL_COUNT_VALUE,
      IDX_WATCHDOG_MODE_CONTROL,
      IDX_WATCHDOG_COMPARE_VALUE,
      IDX_IRQ_STATUS,
      IDX_IRQ_MASK: wr_mapped = 1'b1;
      default: wr_mapped = 1'b0;
    endcase
  end

  assign wr_ictl = wr.fire && w_lane0 && (wr.index == IDX_INTERVAL_CLOCK_CONTROL);
  assign wr_wmode = wr.fire && w_lane0 && (wr.index == IDX_WATCHDOG_MODE_CONTROL);
  assign wr_cmp = wr.fire && w_lane0 && (wr.index == IDX_WATCHDOG_COMPARE_VALUE);
  assign wr_stat = wr.fire && w_lane0 && (wr.index == IDX_IRQ_STATUS);
  assign wr_mask = wr.fire && w_lane0 && (wr.index == IDX_IRQ_MASK);

  always_ff @(posedge core_clk) begin
    if (srst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (wr.fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ---------------- AXI4-Lite read channels ----------------
  assign s_axi_arready = !s_axi_rvalid;
  assign rd_index = s_axi_araddr[11:2];

  always_comb begin
    rd_mapped = 1'b1;
    case (rd_index)
      IDX_INTERVAL_CLOCK_CONTROL: rd_value = {ictl.interval_flag, 3'h0, ictl.interval_clear,
                                              ictl.interval_period_select};
      IDX_INTERVAL_COUNT_VALUE: rd_value = interval_count;
      IDX_WATCHDOG_MODE_CONTROL: rd_value = {wmode.watchdog_run_enable, wmode.watchdog_reset_select,
                                             wmode.watchdog_counter_clear, 4'h0, wmode.watchdog_irq_flag};
      IDX_WATCHDOG_COUNT_VALUE: rd_value = watchdog_count;
      IDX_IRQ_STATUS: rd_value = {6'h00, irq_status};
      IDX_IRQ_MASK: rd_value = {6'h00, irq_mask};
      default: begin
        rd_value = 8'h00;
        rd_mapped = 1'b0;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= {24'h00_0000, rd_value};
      s_axi_rresp <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ---------------- Interval clock prescaler ----------------
  // Divides the core clock down to the interval clock
  always_ff @(posedge core_clk) begin
    if (srst || tick) begin
      presc <= 16'h0000;
    end else begin
      presc <= presc + 16'h0001;
    end
  end

  assign tick = (presc == 16'(TICK_CYCLES - 1));

  // ---------------- Interval counter ----------------
  // No control stops it; only the clear bit and stop exit restart it from zero
  always_ff @(posedge core_clk) begin
    if (srst) begin
      interval_count <= RST_INTERVAL_COUNT_VALUE;
    end else if ((wr_ictl && wr.data[3]) || stop_exit) begin
      interval_count <= 8'h00;
    end else if (tick) begin
      interval_count <= interval_count + 8'h01;
    end
  end

  // Overflow every 2^(select+1) interval ticks
  assign span = 9'h002 << ictl.interval_period_select;
  assign period_mask = 8'(span - 9'h001);
  assign overflow = tick && ((interval_count | ~period_mask) == 8'hFF);
  assign wrap = tick && (interval_count == 8'hFF);

  // ---------------- Interval clock control ----------------
  always_ff @(posedge core_clk) begin
    if (srst) begin
      ictl <= interval_ctrl_t'(RST_INTERVAL_CLOCK_CONTROL);
    end else begin
      ictl.reserved <= 3'h0;
      ictl.interval_clear <= wr_ictl && wr.data[3];
      if (wr_ictl) begin
        ictl.interval_period_select <= wr.data[2:0];
      end
      if (overflow) begin
        ictl.interval_flag <= 1'b1;
      end else if (wr_ictl && !wr.data[7]) begin
        ictl.interval_flag <= 1'b0;
      end
    end
  end

  // ---------------- Clock stabilisation wait ----------------
  // Held from reset or stop exit until the interval counter wraps once
  always_ff @(posedge core_clk) begin
    if (srst || stop_exit) begin
      stab_wait <= 1'b1;
    end else if (wrap) begin
      stab_wait <= 1'b0;
    end
  end

  assign clock_stable = !stab_wait;

  // ---------------- Watchdog compare value ----------------
  always_ff @(posedge core_clk) begin
    if (srst) begin
      compare_value <= RST_WATCHDOG_COMPARE_VALUE;
    end else if (wr_cmp) begin
      compare_value <= wr.data;
    end
  end

  // ---------------- Watchdog counter ----------------
  // Advances only on an interval overflow, never on the core clock alone
  assign match_event = overflow && wmode.watchdog_run_enable &&
                       (watchdog_count == compare_value);

  always_ff @(posedge core_clk) begin
    if (srst) begin
      watchdog_count <= RST_WATCHDOG_COUNT_VALUE;
    end else if (wr_wmode && wr.data[5]) begin
      watchdog_count <= 8'h00;
    end else if (match_event) begin
      watchdog_count <= 8'h00;
    end else if (overflow && wmode.watchdog_run_enable) begin
      watchdog_count <= watchdog_count + 8'h01;
    end
  end

  // ---------------- Watchdog mode control ----------------
  always_ff @(posedge core_clk) begin
    if (srst) begin
      wmode <= watchdog_mode_t'(RST_WATCHDOG_MODE_CONTROL);
    end else begin
      wmode.reserved <= 4'h0;
      wmode.watchdog_counter_clear <= wr_wmode && wr.data[5];
      if (wr_wmode) begin
        wmode.watchdog_run_enable <= wr.data[7];
        wmode.watchdog_reset_select <= wr.data[6];
      end
      if (match_event && !wmode.watchdog_reset_select) begin
        wmode.watchdog_irq_flag <= 1'b1;
      end else if (int_ack || (wr_wmode && !wr.data[0])) begin
        wmode.watchdog_irq_flag <= 1'b0;
      end
    end
  end

  // One-cycle CPU reset request on a match in reset mode
  always_ff @(posedge core_clk) begin
    if (srst) begin
      cpu_reset_req <= 1'b0;
    end else begin
      cpu_reset_req <= match_event && wmode.watchdog_reset_select;
    end
  end

  // ---------------- Interrupt status and mask ----------------
  // An event in the same cycle as a clearing write wins
  always_ff @(posedge core_clk) begin
    if (srst) begin
      irq_status <= RST_IRQ_STATUS;
    end else begin
      if (overflow) begin
        irq_status[IRQ_BIT_INTERVAL] <= 1'b1;
      end else if (wr_stat && wr.data[IRQ_BIT_INTERVAL]) begin
        irq_status[IRQ_BIT_INTERVAL] <= 1'b0;
      end
      if (match_event && !wmode.watchdog_reset_select) begin
        irq_status[IRQ_BIT_WATCHDOG] <= 1'b1;
      end else if (wr_stat && wr.data[IRQ_BIT_WATCHDOG]) begin
        irq_status[IRQ_BIT_WATCHDOG] <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      irq_mask <= RST_IRQ_MASK;
    end else if (wr_mask) begin
      irq_mask <= wr.data[1:0];
    end
  end

  assign irq = |(irq_status & irq_mask);

endmodule : interval_timer_watchdog

`default_nettype wire

// ==== dv/cpu_partner.sv ====
// CPU core model: acknowledges interrupts and counts reset requests
`timescale 1ns/1ns
`default_nettype none
module cpu_partner (
  // Clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // Block side
  input wire logic irq,
  input wire logic cpu_reset_req,
  output logic int_ack,
  // Bench side
  input wire logic ack_en,
  output logic [7:0] resets
);
  logic irq_q;
  logic ack_q;
  assign int_ack = ack_q;
  always_ff @(posedge core_clk) begin
    if (srst) begin
      irq_q <= 1'b0;
      ack_q <= 1'b0;
      resets <= 8'h00;
    end else begin
      irq_q <= irq;
      ack_q <= ack_en && irq && !irq_q;
      if (cpu_reset_req) begin
        resets <= resets + 8'h01;
      end
    end
  end
endmodule : cpu_partner
`default_nettype wire

// ==== dv/itw_asserts.sv ====
// Checker for the interval timer and watchdog ports
`timescale 1ns/1ns
`default_nettype none
module itw_asserts #(
  parameter int TICK_CYCLES = itw_pkg::INTERVAL_TICK_CYCLES
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // Register bus
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // CPU side
  input wire logic stop_exit,
  input wire logic cpu_reset_req,
  input wire logic clock_stable
);
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (srst);
  int wait_cnt;
  always_ff @(posedge core_clk) begin
    if (srst || stop_exit) begin
      wait_cnt <= 0;
    end else if (!clock_stable) begin
      wait_cnt <= wait_cnt + 1;
    end
  end
  a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read unanswered");
  a_rd_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  a_rd_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000) else $error("upper bits set");
  a_wr_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_reset_pulse: assert property (cpu_reset_req |=> !cpu_reset_req) else $error("reset request too long");
  a_wait_restart: assert property (stop_exit |=> !clock_stable) else $error("wait not restarted");
  a_stable_hold: assert property (clock_stable && !stop_exit |=> clock_stable) else $error("stable dropped");
  a_wait_length: assert property ($rose(clock_stable) |-> wait_cnt >= 255 * TICK_CYCLES &&
    wait_cnt <= 256 * TICK_CYCLES + 2) else $error("wait length wrong");
endmodule : itw_asserts
bind interval_timer_watchdog itw_asserts #(.TICK_CYCLES(TICK_CYCLES)) itw_asserts_inst (
  .core_clk, .srst, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .stop_exit, .cpu_reset_req, .clock_stable
);
`default_nettype wire

// ==== dv/tb.sv ====
// Testbench for the interval timer and watchdog
`timescale 1ns/1ns
`default_nettype none
module tb;
  import itw_pkg::*;
  localparam int TICK = 4;
  logic core_clk = 1'b0;
  logic srst = 1'b1;
  logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic stop_exit = 0, ack_en = 1, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic int_ack, irq, cpu_reset_req, clock_stable;
  logic [1:0] s_axi_bresp, s_axi_rresp, rresp;
  logic [7:0] resets, d, e;
  int bad_count = 0, num_checks = 0, cyc = 0, t0, t1, p;
  always #5 core_clk = ~core_clk;
  always @(posedge core_clk) cyc <= cyc + 1;
  interval_timer_watchdog #(.TICK_CYCLES(TICK)) interval_timer_watchdog_inst (
    .core_clk, .srst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .int_ack, .stop_exit, .irq, .cpu_reset_req, .clock_stable
  );
  cpu_partner cpu_partner_inst (.core_clk, .srst, .irq, .cpu_reset_req, .int_ack, .ack_en, .resets);
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] x);
    num_checks++;
    if (s !== x) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", n, x, s);
    end
  endtask : chk
  task automatic wr(input logic [9:0] i, input logic [7:0] v, input logic [1:0] x = RESP_OKAY);
    logic a, w;
    a = 0;
    w = 0;
    @(posedge core_clk);
    s_axi_awaddr <= {i, 2'b00};
    s_axi_wdata <= {24'h000000, v};
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    while (!(a && w)) begin
      @(negedge core_clk);
      a = a || s_axi_awready === 1'b1;
      w = w || s_axi_wready === 1'b1;
      @(posedge core_clk);
      s_axi_awvalid <= !a;
      s_axi_wvalid <= !w;
    end
    do @(negedge core_clk); while (s_axi_bvalid !== 1'b1);
    chk("bresp", s_axi_bresp, x);
    @(posedge core_clk);
    s_axi_bready <= 0;
  endtask : wr
  task automatic rd(input logic [9:0] i, output logic [7:0] v);
    @(posedge core_clk);
    s_axi_araddr <= {i, 2'b00};
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    do @(negedge core_clk); while (s_axi_arready !== 1'b1);
    @(posedge core_clk);
    s_axi_arvalid <= 0;
    do @(negedge core_clk); while (s_axi_rvalid !== 1'b1);
    v = s_axi_rdata[7:0];
    rresp = s_axi_rresp;
    @(posedge core_clk);
    s_axi_rready <= 0;
  endtask : rd
  task automatic rc(input logic [9:0] i, input logic [7:0] x);
    rd(i, d);
    chk($sformatf("reg %h", i), d, x);
  endtask : rc
  // Waits for a low-to-high change; with pv low an already high level counts
  task automatic rise(input bit r, input logic pv, output int t);
    logic c;
    forever begin
      @(negedge core_clk);
      c = r ? cpu_reset_req : irq;
      if (c === 1'b1 && !pv) break;
      pv = c;
    end
    t = cyc;
  endtask : rise
  task automatic per(input bit r, output int q);
    rise(r, 0, t0);
    if (!r) wr(IDX_IRQ_STATUS, 8'h03);
    rise(r, r, t0);
    if (!r) wr(IDX_IRQ_STATUS, 8'h03);
    rise(r, r, t1);
    q = t1 - t0;
  endtask : per
  task automatic t_reset();
    chk("stable", clock_stable, 1'b0);
    rc(IDX_INTERVAL_CLOCK_CONTROL, RST_INTERVAL_CLOCK_CONTROL);
    rc(IDX_WATCHDOG_MODE_CONTROL, 8'h00);
    rc(IDX_WATCHDOG_COUNT_VALUE, 8'h00);
    rc(IDX_IRQ_MASK, 8'h00);
    wr(10'h0FF, 8'hFF, RESP_SLVERR);
    rc(10'h0FF, 8'h00);
    chk("rresp", rresp, RESP_SLVERR);
    do @(negedge core_clk); while (clock_stable !== 1'b1);
  endtask : t_reset
  task automatic t_interval();
    wr(IDX_IRQ_MASK, 8'h01);
    for (int s = 0; s < 8; s++) begin
      wr(IDX_INTERVAL_CLOCK_CONTROL, 8'h08 | 8'(s));
      per(0, p);
      chk("period", p, (2 << s) * TICK);
    end
    rc(IDX_INTERVAL_CLOCK_CONTROL, 8'h87);
    wr(IDX_INTERVAL_CLOCK_CONTROL, 8'h07);
    rc(IDX_INTERVAL_CLOCK_CONTROL, 8'h07);
    wr(IDX_INTERVAL_CLOCK_CONTROL, 8'h0F);
    wr(IDX_INTERVAL_COUNT_VALUE, 8'hAA);
    rd(IDX_INTERVAL_COUNT_VALUE, d);
    chk("count", d <= 8'h02, 1'b1);
  endtask : t_interval
  task automatic t_watchdog();
    wr(IDX_INTERVAL_CLOCK_CONTROL, 8'h01);
    wr(IDX_WATCHDOG_COMPARE_VALUE, 8'h03);
    wr(IDX_IRQ_MASK, 8'h02);
    wr(IDX_WATCHDOG_MODE_CONTROL, 8'hA0);
    rc(IDX_WATCHDOG_MODE_CONTROL, 8'h80);
    per(0, p);
    chk("wd period", p, 4 * 4 * TICK);
    repeat (3) @(posedge core_clk);
    rc(IDX_WATCHDOG_MODE_CONTROL, 8'h80);
    ack_en <= 0;
    wr(IDX_IRQ_STATUS, 8'h03);
    rise(0, 1, t0);
    rc(IDX_WATCHDOG_MODE_CONTROL, 8'h81);
    wr(IDX_IRQ_MASK, 8'h00);
    chk("irq", irq, 1'b0);
    wr(IDX_WATCHDOG_MODE_CONTROL, 8'h80);
    rc(IDX_WATCHDOG_MODE_CONTROL, 8'h80);
    e = resets;
    wr(IDX_WATCHDOG_MODE_CONTROL, 8'hE0);
    per(1, p);
    chk("rst period", p, 4 * 4 * TICK);
    chk("resets", resets - e >= 8'h02, 1'b1);
    rc(IDX_WATCHDOG_MODE_CONTROL, 8'hC0);
    wr(IDX_WATCHDOG_MODE_CONTROL, 8'h00);
    rd(IDX_WATCHDOG_COUNT_VALUE, e);
    repeat (100) @(posedge core_clk);
    rc(IDX_WATCHDOG_COUNT_VALUE, e);
  endtask : t_watchdog
  task automatic t_stop();
    @(posedge core_clk);
    stop_exit <= 1;
    @(posedge core_clk);
    stop_exit <= 0;
    @(negedge core_clk);
    chk("stable", clock_stable, 1'b0);
    do @(negedge core_clk); while (clock_stable !== 1'b1);
  endtask : t_stop
  task automatic conclude();
    if (bad_count == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : conclude
  initial begin
    repeat (30000) @(posedge core_clk);
    bad_count++;
    conclude();
  end
  initial begin
    repeat (20) @(posedge core_clk);
    srst <= 0;
    t_reset();
    t_interval();
    t_watchdog();
    t_stop();
    conclude();
  end
endmodule : tb
`default_nettype wire
